// ==== verilog/ssel_pkg.sv ====
// constants and types of the alignment source selection block
// assumes an axi4-lite master on the core clock, register index = byte address / 4
package ssel_pkg;

	// ======================================================
	// register indices (byte address is four times the index)
	localparam logic [9:0] IDX_RSVD_A = 10'h01C;
	localparam logic [9:0] IDX_RSVD_B = 10'h01D;
	localparam logic [9:0] IDX_CORR_SEL = 10'h01E;
	localparam logic [9:0] IDX_MIX_SEL = 10'h01F;
	localparam logic [9:0] IDX_SHADOW_BASE = 10'h040;
	localparam logic [9:0] IDX_ACTIVE_BASE = 10'h048;
	localparam logic [9:0] IDX_STATUS = 10'h050;

	// ======================================================
	// reset values and mixer write mask
	localparam logic [15:0] RSVD_RST = 16'h0000;
	localparam logic [15:0] CORR_SEL_RST = 16'h1111;
	localparam logic [15:0] MIX_SEL_RST = 16'h1140;
	localparam logic [15:0] MIX_WR_MASK = 16'hFFFE;

	// ======================================================
	// field positions
	localparam int AB_OFS_LSB = 12;
	localparam int CD_OFS_LSB = 8;
	localparam int AB_COR_LSB = 4;
	localparam int CD_COR_LSB = 0;
	localparam int AB_MIX_LSB = 12;
	localparam int CD_MIX_LSB = 8;
	localparam int NCO_LSB = 4;
	localparam int FMT_LSB = 2;
	localparam int SW_PULSE_BIT = 1;
	localparam int RSVD_BIT = 0;

	// ======================================================
	// source positions inside a mask, settings count, codes
	localparam int SRC_SW = 3;
	localparam int SRC_PIN = 2;
	localparam int SRC_STROBE = 1;
	localparam int SRC_AUTO = 0;
	localparam int NUM_SET = 6;
	localparam int NUM_PIN = 3;
	localparam logic [1:0] FMT_FRAME = 2'h0;
	localparam logic [1:0] FMT_PIN = 2'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// settings order: ab offset, cd offset, ab corr, cd corr, ab mixer, cd mixer
	typedef logic [NUM_SET-1:0][15:0] ssel_set_t;
	// pin order: ext align pin, clock align strobe, frame marker
	typedef logic [NUM_PIN-1:0] ssel_pin_t;
	typedef enum {DEC_NONE, DEC_RSVD_A, DEC_RSVD_B, DEC_CORR, DEC_MIX, DEC_SHADOW,
		DEC_ACTIVE, DEC_STATUS} ssel_dec_t;

endpackage

// ==== verilog/ssel_pin_sync.sv ====
// three-stage synchronisers with agreement filter for the alignment pins
// assumes asynchronous pin levels and the core clock aclk
`timescale 1ns/10ps
module ssel_pin_sync import ssel_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pins in, filtered levels out
	input wire ssel_pin_t pin_in,
	output ssel_pin_t pin_lvl
);

	typedef struct packed {
		ssel_pin_t s1;
		ssel_pin_t s2;
		ssel_pin_t s3;
		ssel_pin_t lvl;
	} ssel_sync_state_t;

	ssel_sync_state_t s_reg;
	ssel_sync_state_t s_next;

	// ======================================================
	// shift chain, level taken once stages two and three agree
	always_comb begin
		s_next = s_reg;
		s_next.s1 = pin_in;
		s_next.s2 = s_reg.s1;
		s_next.s3 = s_reg.s2;
		for (int i = 0; i < NUM_PIN; i++) begin
			if (s_reg.s2[i] == s_reg.s3[i]) begin
				s_next.lvl[i] = s_reg.s3[i];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pin_lvl = s_reg.lvl;

endmodule

// ==== verilog/ssel_top.sv ====
// alignment source selection registers with double-buffered settings
// assumes an axi4-lite master on aclk and asynchronous alignment pins
//
// Behaviour
// RULE_01: bits 15:12 of the correction select register pick the ab offset sources, reset 0001.
// RULE_02: bits 11:8 of the correction select register pick the cd offset sources, reset 0001.
// RULE_03: bits 7:4 of the correction select register pick the ab correction sources, reset 0001.
// RULE_04: bits 3:0 of the correction select register pick the cd correction sources, reset 0001.
// RULE_05: bits 15:12 of the mixer select register pick the ab mixer sources, reset 0001.
// RULE_06: bits 11:8 of the mixer select register pick the cd mixer sources, reset 0001.
// RULE_07: mask bits from high to low are software pulse, pin, strobe, auto on write.
// RULE_08: a one enables a source and any enabled source triggers the update.
// RULE_09: bits 7:4 of the mixer select register align the oscillators, frame in bit 4, reset 0100.
// RULE_10: bits 3:2 pick one formatter source: 00 frame, 01 pin, else none, reset 00.
// RULE_11: bit 1 of the mixer select register is the software pulse level, reset zero.
// RULE_12: the two reserved registers and bit 0 of the mixer select register reset to zero.
// RULE_13: settings are written to a shadow copy and moved to active only on an enabled event.
`timescale 1ns/10ps
module ssel_top import ssel_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [11:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [11:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// alignment sources
	input wire logic ext_align_pin,
	input wire logic clock_align_strobe,
	input wire logic frame_marker,
	// settings and alignment outputs
	output ssel_set_t active_settings,
	output logic nco_align,
	output logic format_align
);

	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_got;
		logic w_got;
		logic [9:0] aw_idx;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [15:0] rsvd_a;
		logic [15:0] rsvd_b;
		logic [15:0] corr_sel;
		logic [15:0] mix_sel;
		ssel_set_t shadow;
		ssel_set_t active;
		logic [NUM_SET-1:0] wr_pulse;
		logic [NUM_SET-1:0] pending;
		logic nco_align;
		logic format_align;
	} ssel_state_t;

	ssel_state_t s_reg;
	ssel_state_t s_next;
	ssel_pin_t pin_lvl;
	logic [NUM_SET-1:0][3:0] mask;
	logic [NUM_SET-1:0] hit;
	logic sw_lvl;
	logic [3:0] nco_mask;
	ssel_dec_t wr_dec;
	ssel_dec_t rd_dec;
	logic [2:0] wr_sub;
	logic [2:0] rd_sub;

	// ======================================================
	// pin synchronisers
	ssel_pin_sync ssel_pin_sync_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in({frame_marker, clock_align_strobe, ext_align_pin}),
		.pin_lvl(pin_lvl)
	);

	// ======================================================
	// address decode and byte merge
	function automatic ssel_dec_t ssel_decode(input logic [9:0] idx);
		ssel_dec_t d;
		d = DEC_NONE;
		if (idx == IDX_RSVD_A) begin
			d = DEC_RSVD_A;
		end else if (idx == IDX_RSVD_B) begin
			d = DEC_RSVD_B;
		end else if (idx == IDX_CORR_SEL) begin
			d = DEC_CORR;
		end else if (idx == IDX_MIX_SEL) begin
			d = DEC_MIX;
		end else if (idx == IDX_STATUS) begin
			d = DEC_STATUS;
		end else if (idx[9:3] == IDX_SHADOW_BASE[9:3] && idx[2:0] < 3'(NUM_SET)) begin
			d = DEC_SHADOW;
		end else if (idx[9:3] == IDX_ACTIVE_BASE[9:3] && idx[2:0] < 3'(NUM_SET)) begin
			d = DEC_ACTIVE;
		end
		return d;
	endfunction

	function automatic logic [15:0] ssel_merge(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = data[7:0];
		end
		if (strb[1]) begin
			r[15:8] = data[15:8];
		end
		return r;
	endfunction

	// ======================================================
	// next state
	always_comb begin
		s_next = s_reg;
		s_next.wr_pulse = '0;
		mask[0] = s_reg.corr_sel[AB_OFS_LSB +: 4]; // RULE_01
		mask[1] = s_reg.corr_sel[CD_OFS_LSB +: 4]; // RULE_02
		mask[2] = s_reg.corr_sel[AB_COR_LSB +: 4]; // RULE_03
		mask[3] = s_reg.corr_sel[CD_COR_LSB +: 4]; // RULE_04
		mask[4] = s_reg.mix_sel[AB_MIX_LSB +: 4]; // RULE_05
		mask[5] = s_reg.mix_sel[CD_MIX_LSB +: 4]; // RULE_06
		nco_mask = s_reg.mix_sel[NCO_LSB +: 4];
		sw_lvl = s_reg.mix_sel[SW_PULSE_BIT]; // RULE_11
		wr_dec = ssel_decode(s_reg.aw_idx);
		rd_dec = ssel_decode(araddr[11:2]);
		wr_sub = s_reg.aw_idx[2:0];
		rd_sub = araddr[4:2];

		// double-buffer transfers
		for (int i = 0; i < NUM_SET; i++) begin
			hit[i] = |(mask[i] & {sw_lvl, pin_lvl[0], pin_lvl[1], s_reg.wr_pulse[i]}); // RULE_07 RULE_08
			if (hit[i]) begin
				s_next.active[i] = s_reg.shadow[i]; // RULE_13
				s_next.pending[i] = 1'b0;
			end
		end
		s_next.nco_align = |(nco_mask & {sw_lvl, pin_lvl[0], pin_lvl[1], pin_lvl[2]}); // RULE_09
		case (s_reg.mix_sel[FMT_LSB +: 2])
			FMT_FRAME: s_next.format_align = pin_lvl[2]; // RULE_10
			FMT_PIN: s_next.format_align = pin_lvl[0]; // RULE_10
			default: s_next.format_align = 1'b0; // RULE_10
		endcase

		// write channel capture
		if (awvalid && s_reg.awready) begin
			s_next.aw_got = 1'b1;
			s_next.aw_idx = awaddr[11:2];
		end
		if (wvalid && s_reg.wready) begin
			s_next.w_got = 1'b1;
			s_next.w_data = wdata;
			s_next.w_strb = wstrb;
		end
		if (s_reg.bvalid && bready) begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = RESP_OKAY;
			case (wr_dec)
				DEC_RSVD_A: s_next.rsvd_a = ssel_merge(s_reg.rsvd_a, s_reg.w_data, s_reg.w_strb);
				DEC_RSVD_B: s_next.rsvd_b = ssel_merge(s_reg.rsvd_b, s_reg.w_data, s_reg.w_strb);
				DEC_CORR: s_next.corr_sel = ssel_merge(s_reg.corr_sel, s_reg.w_data, s_reg.w_strb);
				DEC_MIX: begin
					s_next.mix_sel = ssel_merge(s_reg.mix_sel, s_reg.w_data, s_reg.w_strb)
						& MIX_WR_MASK; // RULE_12
				end
				DEC_SHADOW: begin
					s_next.shadow[wr_sub] = ssel_merge(s_reg.shadow[wr_sub], s_reg.w_data,
						s_reg.w_strb); // RULE_13
					s_next.wr_pulse[wr_sub] = 1'b1;
					s_next.pending[wr_sub] = 1'b1;
				end
				DEC_ACTIVE: s_next.bresp = RESP_OKAY;
				DEC_STATUS: s_next.bresp = RESP_OKAY;
				default: s_next.bresp = RESP_SLVERR;
			endcase
		end
		s_next.awready = !s_next.aw_got;
		s_next.wready = !s_next.w_got;

		// read channel
		if (arvalid && s_reg.arready) begin
			s_next.arready = 1'b0;
			s_next.rvalid = 1'b1;
			s_next.rresp = RESP_OKAY;
			case (rd_dec)
				DEC_RSVD_A: s_next.rdata = {16'h0000, s_reg.rsvd_a};
				DEC_RSVD_B: s_next.rdata = {16'h0000, s_reg.rsvd_b};
				DEC_CORR: s_next.rdata = {16'h0000, s_reg.corr_sel};
				DEC_MIX: s_next.rdata = {16'h0000, s_reg.mix_sel};
				DEC_SHADOW: s_next.rdata = {16'h0000, s_reg.shadow[rd_sub]};
				DEC_ACTIVE: s_next.rdata = {16'h0000, s_reg.active[rd_sub]};
				DEC_STATUS: s_next.rdata = {23'h0, pin_lvl, s_reg.pending};
				default: begin
					s_next.rdata = 32'h00000000;
					s_next.rresp = RESP_SLVERR;
				end
			endcase
		end else if (s_reg.rvalid && rready) begin
			s_next.rvalid = 1'b0;
			s_next.arready = 1'b1;
		end
	end

	// ======================================================
	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.awready <= 1'b1;
			s_reg.wready <= 1'b1;
			s_reg.arready <= 1'b1;
			s_reg.rsvd_a <= RSVD_RST; // RULE_12
			s_reg.rsvd_b <= RSVD_RST; // RULE_12
			s_reg.corr_sel <= CORR_SEL_RST; // RULE_01 RULE_02 RULE_03 RULE_04
			s_reg.mix_sel <= MIX_SEL_RST; // RULE_05 RULE_06 RULE_09 RULE_10 RULE_11
		end else begin
			s_reg <= s_next;
		end
	end

	// ======================================================
	// outputs
	assign awready = s_reg.awready;
	assign wready = s_reg.wready;
	assign bvalid = s_reg.bvalid;
	assign bresp = s_reg.bresp;
	assign arready = s_reg.arready;
	assign rvalid = s_reg.rvalid;
	assign rdata = s_reg.rdata;
	assign rresp = s_reg.rresp;
	assign active_settings = s_reg.active;
	assign nco_align = s_reg.nco_align;
	assign format_align = s_reg.format_align;

	// ======================================================
	// checks
	ab_ofs_sw_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_01
		(sw_lvl && s_reg.corr_sel[15]) |=> active_settings[0] == $past(s_reg.shadow[0]))
		else $error("ab offset not moved on software pulse");
	cd_ofs_pin_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_02
		(pin_lvl[0] && s_reg.corr_sel[10]) |=> active_settings[1] == $past(s_reg.shadow[1]))
		else $error("cd offset not moved on pin");
	ab_cor_strobe_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_03
		(pin_lvl[1] && s_reg.corr_sel[5]) |=> active_settings[2] == $past(s_reg.shadow[2]))
		else $error("ab correction not moved on strobe");
	cd_cor_auto_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_04
		(s_reg.wr_pulse[3] && s_reg.corr_sel[0]) |=> active_settings[3] == $past(s_reg.shadow[3]))
		else $error("cd correction not moved on write");
	ab_mix_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_05
		(s_reg.mix_sel[15:12] == 4'h0) |=> $stable(active_settings[4]))
		else $error("ab mixer moved with no source enabled");
	cd_mix_strobe_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_06
		(pin_lvl[1] && s_reg.mix_sel[9]) |=> active_settings[5] == $past(s_reg.shadow[5]))
		else $error("cd mixer not moved on strobe");
	any_src_clr_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_08
		(hit[0] && !s_reg.wr_pulse[0] && !(s_reg.aw_got && s_reg.w_got)) |=> !s_reg.pending[0])
		else $error("pending kept after enabled event");
	nco_frame_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_09
		(pin_lvl[2] && s_reg.mix_sel[4]) |=> nco_align)
		else $error("oscillator align missing on frame");
	fmt_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_10
		(s_reg.mix_sel[3]) |=> !format_align)
		else $error("formatter aligned while disabled");
	fmt_pin_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_10
		(s_reg.mix_sel[3:2] == FMT_PIN) |=> format_align == $past(pin_lvl[0]))
		else $error("formatter not following pin");
	rsvd_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_12
		s_reg.mix_sel[RSVD_BIT] == 1'b0)
		else $error("reserved bit set");
	shadow_only_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_13
		(hit == '0) |=> $stable(active_settings))
		else $error("active copy changed with no event");

endmodule

// ==== bench/ssel_top_tb.sv ====
// self-checking bench of the alignment source selection block
// assumes ssel_pkg and ssel_top compiled first; drives axi4-lite and pins itself
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
	$display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp); end end
module ssel_top_tb import ssel_pkg::*;;
	// ======================================================
	// signals
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid, nco_align, format_align;
	logic [1:0] bresp, rresp, resp;
	logic ext_align_pin = 1'b0, clock_align_strobe = 1'b0, frame_marker = 1'b0;
	ssel_set_t act;
	logic [15:0] exp_a [NUM_SET];
	logic [15:0] val [NUM_SET];
	int n_errors = 0;
	int tests_run = 0;

	ssel_top ssel_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .ext_align_pin(ext_align_pin),
		.clock_align_strobe(clock_align_strobe), .frame_marker(frame_marker),
		.active_settings(act), .nco_align(nco_align), .format_align(format_align));

	initial begin
		forever #5 aclk = ~aclk;
	end

	// ======================================================
	// bus tasks
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		r = 2'h3;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
			n++;
		end
		`CHK(n, 2, "write latency")
	endtask

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		d = 32'h0;
		r = 2'h3;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
			n++;
		end
		`CHK(n, 1, "read latency")
	endtask

	task automatic rd_chk(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd({idx, 2'b00}, d, r);
		`CHK(d, ed, "read data")
		`CHK(r, er, "read resp")
	endtask

	task automatic wr(input logic [9:0] idx, input logic [15:0] d);
		axi_wr({idx, 2'b00}, {16'h0, d}, resp);
		`CHK(resp, RESP_OKAY, "write resp")
		repeat (4) @(posedge aclk);
	endtask

	task automatic set_src(input logic e, input logic s, input logic f);
		@(posedge aclk);
		ext_align_pin <= e;
		clock_align_strobe <= s;
		frame_marker <= f;
		repeat (8) @(posedge aclk);
	endtask

	task automatic chk_act();
		for (int i = 0; i < NUM_SET; i++) `CHK(act[i], exp_a[i], "active setting")
	endtask

	// ======================================================
	// closing
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#200000;
		n_errors++;
		wrap_up();
	end

	// ======================================================
	// tests
	initial begin
		logic [31:0] d;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(IDX_RSVD_A, 32'h0, RESP_OKAY);
		rd_chk(IDX_RSVD_B, 32'h0, RESP_OKAY);
		rd_chk(IDX_CORR_SEL, 32'h1111, RESP_OKAY);
		rd_chk(IDX_MIX_SEL, 32'h1140, RESP_OKAY);
		rd_chk(IDX_ACTIVE_BASE, 32'h0, RESP_OKAY);
		rd_chk(10'h3FF, 32'h0, RESP_SLVERR);
		axi_wr(12'hFFC, 32'h1234, resp);
		`CHK(resp, RESP_SLVERR, "unmapped write")
		wr(IDX_MIX_SEL, 16'hFFFF);
		rd_chk(IDX_MIX_SEL, 32'hFFFE, RESP_OKAY);
		$display("test reset_and_map done");
		// sw on ab ofs, pin on cd ofs, strobe on ab cor, auto on cd cor
		wr(IDX_CORR_SEL, 16'h8421);
		// ab mixer none, cd mixer pin or strobe, osc pin, formatter off
		wr(IDX_MIX_SEL, 16'h0648);
		for (int i = 0; i < NUM_SET; i++) begin
			val[i] = 16'h1234 + 16'h1111 * i;
			exp_a[i] = 16'h0;
			wr(IDX_SHADOW_BASE + 10'(i), val[i]);
		end
		exp_a[3] = val[3];
		chk_act();
		rd_chk(IDX_STATUS, 32'h00000037, RESP_OKAY);
		rd_chk(IDX_ACTIVE_BASE + 10'h003, {16'h0000, val[3]}, RESP_OKAY);
		set_src(1'b0, 1'b1, 1'b0);
		exp_a[2] = val[2];
		exp_a[5] = val[5];
		chk_act();
		`CHK(nco_align, 1'b0, "osc align on strobe")
		set_src(1'b1, 1'b0, 1'b0);
		exp_a[1] = val[1];
		chk_act();
		`CHK(nco_align, 1'b1, "osc align on pin")
		`CHK(format_align, 1'b0, "formatter off")
		set_src(1'b0, 1'b0, 1'b0);
		wr(IDX_MIX_SEL, 16'h064A);
		rd_chk(IDX_MIX_SEL, 32'h064A, RESP_OKAY);
		exp_a[0] = val[0];
		chk_act();
		wr(IDX_MIX_SEL, 16'h0648);
		wr(IDX_SHADOW_BASE, 16'hBEEF);
		repeat (4) @(posedge aclk);
		chk_act();
		$display("test source_masks done");
		// osc mask on frame marker
		wr(IDX_MIX_SEL, 16'h0618);
		set_src(1'b0, 1'b0, 1'b1);
		`CHK(nco_align, 1'b1, "osc align on frame")
		set_src(1'b1, 1'b0, 1'b0);
		`CHK(nco_align, 1'b0, "osc align pin masked")
		set_src(1'b0, 1'b0, 1'b0);
		$display("test osc_align done");
		for (int c = 0; c < 4; c++) begin
			wr(IDX_MIX_SEL, 16'(c << FMT_LSB));
			set_src(1'b0, 1'b0, 1'b1);
			`CHK(format_align, 1'(c == 0), "formatter on frame")
			set_src(1'b1, 1'b0, 1'b0);
			`CHK(format_align, 1'(c == 1), "formatter on pin")
			set_src(1'b0, 1'b0, 1'b0);
		end
		$display("test formatter done");
		wrap_up();
	end
endmodule
